// >>> rtl/aoipr_pkg.sv
// Functional notes
// [RULE_01] Bit-mapping field 7-5: 001 two-lane 18/14, 010 two-lane 16, 011 one, 100 half.
// [RULE_02] A written bit-mapping value takes effect only on a fuse-load command.
// [RULE_03] Host writes interface config and fuse load first; fuse load clears other settings.
// [RULE_04] Fuse default mapping applies after reset; field reads 000 until written.
// [RULE_05] Override enable bit 3 gates lane-mode field 2-0 over the fuse default.
// [RULE_06] Lane-mode field: 011 two-lane, 100 one-lane, 101 half-lane; others unused.
// [RULE_07] Fuse default lane mode loads after reset; field reads 000 until written.
// [RULE_08] Power-down bit 5 turns off the sampling clock buffer; resets to 0.
// [RULE_09] Power-down bit 4 turns off the reference gain amplifier; resets to 0.
// [RULE_10] Power-down bit 2 turns off converter channel A.
// [RULE_11] Power-down bit 1 turns off converter channel B; resets to 0.
// [RULE_12] Power-down bit 0 is global sleep; mask register picks what turns off.
// [RULE_13] Output power-down: bit 5 frame clock, bit 4 bit clock, bits 3-0 lanes.
// [RULE_14] A 1 in an output power-down bit turns that output buffer off.
// [RULE_15] Fewer lanes never powers down unused lane buffers by itself.
// [RULE_16] Global sleep: clock buffer, amp off unless masked; bandgap off only if masked.
// [RULE_17] Software writes zero to all reserved bits of these registers.
package aoipr_pkg;

    // ********************************
    // SPI frame
    // ********************************
    localparam int ADDR_W      = 12;
    localparam int FRAME_BITS  = 24;
    localparam int HDR_BITS    = 16;
    localparam int HDR_RD_POS  = 15;

    // ********************************
    // Register map
    // ********************************
    localparam logic [11:0] ADDR_IF_CFG   = 12'h007;
    localparam logic [11:0] ADDR_CORE_PDN = 12'h008;
    localparam logic [11:0] ADDR_OUT_PDN  = 12'h009;
    localparam logic [11:0] ADDR_PDN_MASK = 12'h00d;
    localparam logic [11:0] ADDR_FUSE_LD  = 12'h013;

    localparam logic [7:0] RST_IF_CFG   = 8'h00;
    localparam logic [7:0] RST_CORE_PDN = 8'h00;
    localparam logic [7:0] RST_OUT_PDN  = 8'h00;
    localparam logic [7:0] RST_PDN_MASK = 8'h00;

    // Implemented bits; reserved ones are not stored and read 0
    localparam logic [7:0] MSK_IF_CFG   = 8'hef;
    localparam logic [7:0] MSK_CORE_PDN = 8'h37;
    localparam logic [7:0] MSK_OUT_PDN  = 8'h3f;
    localparam logic [7:0] MSK_PDN_MASK = 8'h0e;

    // Field positions
    localparam int POS_MAP_LSB   = 5;
    localparam int POS_OVR_EN    = 3;
    localparam int POS_LANE_LSB  = 0;
    localparam int POS_CLKBUF    = 5;
    localparam int POS_REFAMP    = 4;
    localparam int POS_CHAN_A    = 2;
    localparam int POS_CHAN_B    = 1;
    localparam int POS_GLOBAL    = 0;
    localparam int POS_FRAME_CLK = 5;
    localparam int POS_BIT_CLK   = 4;
    localparam int POS_A_LANE1   = 3;
    localparam int POS_A_LANE0   = 2;
    localparam int POS_B_LANE1   = 1;
    localparam int POS_B_LANE0   = 0;
    localparam int POS_KEEP_CLK  = 3;
    localparam int POS_KEEP_AMP  = 2;
    localparam int POS_BG_SLEEP  = 1;
    localparam int POS_FUSE_LD   = 0;

    // ********************************
    // Field encodings
    // ********************************
    localparam logic [2:0] MAP_CODE_2L_18 = 3'h1;
    localparam logic [2:0] MAP_CODE_2L_16 = 3'h2;
    localparam logic [2:0] MAP_CODE_1L    = 3'h3;
    localparam logic [2:0] MAP_CODE_HALF  = 3'h4;
    localparam logic [2:0] LANE_CODE_2L   = 3'h3;
    localparam logic [2:0] LANE_CODE_1L   = 3'h4;
    localparam logic [2:0] LANE_CODE_HALF = 3'h5;

    typedef enum logic [2:0] {
        MAP_UNUSED,
        MAP_TWO_LANE_18_14,
        MAP_TWO_LANE_16,
        MAP_ONE_LANE,
        MAP_HALF_LANE
    } aoipr_map_t;

    typedef enum logic [1:0] {
        LANE_UNUSED,
        LANE_TWO,
        LANE_ONE,
        LANE_HALF
    } aoipr_lane_t;

    typedef struct packed {
        logic sclk;
        logic sen_n;
        logic sdi;
    } aoipr_spi_t;

    typedef struct packed {
        logic clock_buffer_off;
        logic reference_amp_off;
        logic bandgap_off;
        logic channel_a_off;
        logic channel_b_off;
        logic frame_clock_buffer_off;
        logic bit_clock_buffer_off;
        logic chan_a_lane1_off;
        logic chan_a_lane0_off;
        logic chan_b_lane1_off;
        logic chan_b_lane0_off;
    } aoipr_pwr_t;

endpackage

// >>> rtl/aoipr_pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module aoipr_pin_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         sys_clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_out
);

    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] agree;

    // Only bits whose last two stages agree may move
    assign agree = ~(s2_r ^ s3_r);

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            // Start at the pins' idle levels so no false edge follows reset
            s1_r    <= RST_VAL;
            s2_r    <= RST_VAL;
            s3_r    <= RST_VAL;
            pin_out <= RST_VAL;
        end else begin
            s1_r    <= pin_in;
            s2_r    <= s1_r;
            s3_r    <= s2_r;
            pin_out <= (agree & s3_r) | (~agree & pin_out);
        end
    end

endmodule
`default_nettype wire

// >>> rtl/aoipr_regs.sv
`timescale 1ns/10ps
`default_nettype none
module aoipr_regs (
    input  wire logic                   sys_clk,
    input  wire logic                   nrst,
    input  wire aoipr_pkg::aoipr_spi_t  spi_in,
    output logic                        sdout,
    output logic                        sdout_oe,
    input  wire logic [2:0]             fuse_bit_mapping,
    input  wire logic [2:0]             fuse_lane_mode,
    output aoipr_pkg::aoipr_map_t       output_bit_mapping,
    output aoipr_pkg::aoipr_lane_t      lane_mode,
    output aoipr_pkg::aoipr_pwr_t       pwr
);
    import aoipr_pkg::*;

    // ********************************
    // Pin synchronisers
    // ********************************
    aoipr_spi_t spi_q;
    logic       sclk_d_r;
    logic       sclk_rise;
    logic       sclk_fall;
    logic       frame_on;

    // Select idles high, clock and data low
    aoipr_pin_sync #(.W(3), .RST_VAL(3'h2)) u_sync (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .pin_in  (spi_in),
        .pin_out (spi_q)
    );

    assign frame_on  = ~spi_q.sen_n;
    assign sclk_rise = frame_on & spi_q.sclk & ~sclk_d_r;
    assign sclk_fall = frame_on & ~spi_q.sclk & sclk_d_r;

    // ********************************
    // SPI shifter
    // ********************************
    logic [4:0]        bit_cnt_r;
    logic [22:0]       shift_r;
    logic [15:0]       hdr_r;
    logic [7:0]        out_shift_r;
    logic              rd_phase_r;
    logic [15:0]       hdr_now;
    logic              hdr_done;
    logic              last_bit;
    logic              wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [7:0]        wr_data;
    logic [7:0]        rd_data;

    assign hdr_now  = {shift_r[14:0], spi_q.sdi};
    assign hdr_done = sclk_rise && (bit_cnt_r == 5'(HDR_BITS - 1));
    assign last_bit = sclk_rise && (bit_cnt_r == 5'(FRAME_BITS - 1));
    assign wr_en    = last_bit & ~hdr_r[HDR_RD_POS];
    assign wr_addr  = hdr_r[ADDR_W-1:0];
    assign wr_data  = {shift_r[6:0], spi_q.sdi};

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sclk_d_r <= 1'b0;
            bit_cnt_r <= '0;
            shift_r <= '0;
            hdr_r <= '0;
        end else begin
            sclk_d_r <= spi_q.sclk;
            if (!frame_on) begin
                bit_cnt_r <= '0;
            end else if (sclk_rise) begin
                shift_r <= {shift_r[21:0], spi_q.sdi};
                bit_cnt_r <= last_bit ? '0 : bit_cnt_r + 5'h01;
                if (hdr_done) begin
                    hdr_r <= hdr_now;
                end
            end
        end
    end

    // Read data leaves on falling edges so the host samples it on rising ones
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            out_shift_r <= '0;
            rd_phase_r <= 1'b0;
            sdout <= 1'b0;
        end else begin
            if (!frame_on || last_bit) begin
                rd_phase_r <= 1'b0;
            end else if (hdr_done) begin
                rd_phase_r <= hdr_now[HDR_RD_POS];
                out_shift_r <= rd_data;
            end else if (sclk_fall && rd_phase_r) begin
                sdout <= out_shift_r[7];
                out_shift_r <= {out_shift_r[6:0], 1'b0};
            end
        end
    end

    assign sdout_oe = rd_phase_r;

    // ********************************
    // Register file
    // ********************************
    logic [7:0] if_cfg_r;
    logic [7:0] core_pdn_r;
    logic [7:0] out_pdn_r;
    logic [7:0] pdn_mask_r;
    logic       map_written_r;
    logic       fuse_seen_r;
    logic [2:0] fuse_map_r;
    logic [2:0] fuse_lane_r;
    logic [2:0] eff_map_r;
    logic       wr_if;
    logic       wr_core;
    logic       wr_out;
    logic       wr_mask;
    logic       fuse_ld;
    logic [2:0] rd_addr_sel;
    logic [ADDR_W-1:0] rd_addr;

    assign wr_if   = wr_en && (wr_addr == ADDR_IF_CFG);
    assign wr_core = wr_en && (wr_addr == ADDR_CORE_PDN);
    assign wr_out  = wr_en && (wr_addr == ADDR_OUT_PDN);
    assign wr_mask = wr_en && (wr_addr == ADDR_PDN_MASK);
    assign fuse_ld = wr_en && (wr_addr == ADDR_FUSE_LD) && wr_data[POS_FUSE_LD]; // RULE_02

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            if_cfg_r <= RST_IF_CFG;
            map_written_r <= 1'b0;
        end else if (wr_if) begin
            // Reserved bits are dropped rather than stored
            if_cfg_r <= wr_data & MSK_IF_CFG; // RULE_17
            map_written_r <= 1'b1;
        end
    end

    // Fuse load restores the other settings, so the host must order it first
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            core_pdn_r <= RST_CORE_PDN;
            out_pdn_r <= RST_OUT_PDN;
            pdn_mask_r <= RST_PDN_MASK;
        end else if (fuse_ld) begin
            core_pdn_r <= RST_CORE_PDN; // RULE_03
            out_pdn_r <= RST_OUT_PDN;
            pdn_mask_r <= RST_PDN_MASK;
        end else begin
            if (wr_core) begin
                core_pdn_r <= wr_data & MSK_CORE_PDN; // RULE_17
            end
            if (wr_out) begin
                out_pdn_r <= wr_data & MSK_OUT_PDN; // RULE_13
            end
            if (wr_mask) begin
                pdn_mask_r <= wr_data & MSK_PDN_MASK;
            end
        end
    end

    // Fuse values are caught on the first edge after reset release
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            fuse_seen_r <= 1'b0;
            fuse_map_r <= '0;
            fuse_lane_r <= '0;
            eff_map_r <= '0;
        end else if (!fuse_seen_r) begin
            fuse_seen_r <= 1'b1;
            fuse_map_r <= fuse_bit_mapping;
            fuse_lane_r <= fuse_lane_mode; // RULE_07
            eff_map_r <= fuse_bit_mapping; // RULE_04
        end else if (fuse_ld) begin
            eff_map_r <= map_written_r ? if_cfg_r[POS_MAP_LSB +: 3] : fuse_map_r; // RULE_02
        end
    end

    // Readback shows stored bits only, so unwritten fields read 000
    assign rd_addr = hdr_now[ADDR_W-1:0];
    assign rd_addr_sel = (rd_addr == ADDR_IF_CFG)   ? 3'h1 :
                         (rd_addr == ADDR_CORE_PDN) ? 3'h2 :
                         (rd_addr == ADDR_OUT_PDN)  ? 3'h3 :
                         (rd_addr == ADDR_PDN_MASK) ? 3'h4 : 3'h0;
    assign rd_data = (rd_addr_sel == 3'h1) ? if_cfg_r :
                     (rd_addr_sel == 3'h2) ? core_pdn_r :
                     (rd_addr_sel == 3'h3) ? out_pdn_r :
                     (rd_addr_sel == 3'h4) ? pdn_mask_r : 8'h00;

    // ********************************
    // Mode decode
    // ********************************
    logic [2:0]  lane_code;
    aoipr_map_t  map_nxt;
    aoipr_lane_t lane_nxt;

    assign lane_code = if_cfg_r[POS_OVR_EN] ? if_cfg_r[POS_LANE_LSB +: 3] : fuse_lane_r; // RULE_05

    assign map_nxt = (eff_map_r == MAP_CODE_2L_18) ? MAP_TWO_LANE_18_14 : // RULE_01
                     (eff_map_r == MAP_CODE_2L_16) ? MAP_TWO_LANE_16 :
                     (eff_map_r == MAP_CODE_1L)    ? MAP_ONE_LANE :
                     (eff_map_r == MAP_CODE_HALF)  ? MAP_HALF_LANE : MAP_UNUSED;

    assign lane_nxt = (lane_code == LANE_CODE_2L)   ? LANE_TWO : // RULE_06
                      (lane_code == LANE_CODE_1L)   ? LANE_ONE :
                      (lane_code == LANE_CODE_HALF) ? LANE_HALF : LANE_UNUSED;

    // ********************************
    // Power controls
    // ********************************
    aoipr_pwr_t pwr_nxt;
    logic       glob;

    assign glob = core_pdn_r[POS_GLOBAL]; // RULE_12

    assign pwr_nxt.clock_buffer_off  = core_pdn_r[POS_CLKBUF] | (glob & ~pdn_mask_r[POS_KEEP_CLK]); // RULE_08 RULE_16
    assign pwr_nxt.reference_amp_off = core_pdn_r[POS_REFAMP] | (glob & ~pdn_mask_r[POS_KEEP_AMP]); // RULE_09 RULE_16
    assign pwr_nxt.bandgap_off       = glob & pdn_mask_r[POS_BG_SLEEP]; // RULE_16
    assign pwr_nxt.channel_a_off     = core_pdn_r[POS_CHAN_A] | glob; // RULE_10 RULE_12
    assign pwr_nxt.channel_b_off     = core_pdn_r[POS_CHAN_B] | glob; // RULE_11 RULE_12
    // Lane buffers follow software only; lane mode does not touch them
    assign pwr_nxt.frame_clock_buffer_off = out_pdn_r[POS_FRAME_CLK]; // RULE_14
    assign pwr_nxt.bit_clock_buffer_off   = out_pdn_r[POS_BIT_CLK]; // RULE_14
    assign pwr_nxt.chan_a_lane1_off       = out_pdn_r[POS_A_LANE1]; // RULE_15
    assign pwr_nxt.chan_a_lane0_off       = out_pdn_r[POS_A_LANE0]; // RULE_14
    assign pwr_nxt.chan_b_lane1_off       = out_pdn_r[POS_B_LANE1]; // RULE_15
    assign pwr_nxt.chan_b_lane0_off       = out_pdn_r[POS_B_LANE0]; // RULE_15

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            output_bit_mapping <= MAP_UNUSED;
            lane_mode <= LANE_UNUSED;
            pwr <= '0;
        end else begin
            output_bit_mapping <= map_nxt;
            lane_mode <= lane_nxt;
            pwr <= pwr_nxt;
        end
    end

endmodule
`default_nettype wire

// >>> dv/aoipr_regs_props.sv
`timescale 1ns/10ps
`default_nettype none
module aoipr_regs_props (
    input wire logic                   sys_clk,
    input wire logic                   nrst,
    input wire aoipr_pkg::aoipr_spi_t  spi_in,
    input wire logic                   sdout,
    input wire logic                   sdout_oe,
    input wire logic [2:0]             fuse_bit_mapping,
    input wire logic [2:0]             fuse_lane_mode,
    input wire aoipr_pkg::aoipr_map_t  output_bit_mapping,
    input wire aoipr_pkg::aoipr_lane_t lane_mode,
    input wire aoipr_pkg::aoipr_pwr_t  pwr
);
    import aoipr_pkg::*;
    logic [3:0]  idle_cnt_r;
    logic [2:0]  boot_cnt_r;
    logic        quiet;
    aoipr_map_t  fuse_map_exp;
    aoipr_lane_t fuse_lane_exp;
    assign fuse_map_exp = (fuse_bit_mapping inside {[3'h1:3'h4]}) ? aoipr_map_t'(fuse_bit_mapping) : MAP_UNUSED;
    assign fuse_lane_exp = (fuse_lane_mode == LANE_CODE_2L) ? LANE_TWO :
                           (fuse_lane_mode == LANE_CODE_1L) ? LANE_ONE :
                           (fuse_lane_mode == LANE_CODE_HALF) ? LANE_HALF : LANE_UNUSED;
    // 8 idle clocks: no write can still sit in the pin synchroniser
    assign quiet = (idle_cnt_r >= 4'h8) && (boot_cnt_r >= 3'h4);
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            idle_cnt_r <= 4'h0;
            boot_cnt_r <= 3'h0;
        end else begin
            idle_cnt_r <= spi_in.sen_n ? idle_cnt_r + {3'h0, idle_cnt_r != 4'hf} : 4'h0;
            boot_cnt_r <= boot_cnt_r + {2'h0, boot_cnt_r != 3'h7};
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    a_map_legal: assert property (output_bit_mapping inside {[MAP_UNUSED:MAP_HALF_LANE]})
        else $error("bit mapping outside its codes");
    a_map_fuse: assert property ($rose(nrst) |-> ##[1:3] output_bit_mapping == fuse_map_exp)
        else $error("fuse mapping not applied after reset");
    a_lane_fuse: assert property ($rose(nrst) |-> ##[1:3] lane_mode == fuse_lane_exp)
        else $error("fuse lane mode not applied after reset");
    a_map_quiet: assert property (quiet |=> $stable(output_bit_mapping))
        else $error("bit mapping moved without a command");
    a_lane_quiet: assert property (quiet |=> $stable(lane_mode))
        else $error("lane mode moved without a write");
    a_pwr_quiet: assert property (quiet |=> $stable(pwr))
        else $error("power controls moved without a write");
    a_lanes_kept: assert property ($changed(lane_mode) |-> $stable(pwr[3:0]))
        else $error("lane buffers changed with lane mode");
    a_sleep_chan: assert property (pwr.bandgap_off |-> pwr.channel_a_off && pwr.channel_b_off)
        else $error("bandgap off outside global sleep");
    a_oe_quiet: assert property (quiet |-> !sdout_oe)
        else $error("read driver still on while deselected");
    cover property ($changed(output_bit_mapping));
    cover property (lane_mode == LANE_HALF);
    cover property (pwr.bandgap_off);
    cover property ($rose(sdout_oe));
endmodule
bind aoipr_regs aoipr_regs_props i_props (
    .sys_clk(sys_clk), .nrst(nrst), .spi_in(spi_in), .sdout(sdout), .sdout_oe(sdout_oe),
    .fuse_bit_mapping(fuse_bit_mapping), .fuse_lane_mode(fuse_lane_mode),
    .output_bit_mapping(output_bit_mapping), .lane_mode(lane_mode), .pwr(pwr));
`default_nettype wire

// >>> dv/aoipr_spi_host.sv
`timescale 1ns/10ps
`default_nettype none
module aoipr_spi_host (
    input wire logic                  sys_clk,
    output var aoipr_pkg::aoipr_spi_t spi,
    input wire logic                  sdout
);
    import aoipr_pkg::*;
    localparam int HALF = 8;
    initial spi = 3'b010;
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // Read bits sampled late in the low phase, after the synced fall
    task automatic xfer(input logic rd, input logic [11:0] addr,
                        input logic [7:0] wdata, output logic [7:0] rdata);
        logic [23:0] frame;
        frame = {rd, 3'h0, addr, wdata};
        rdata = 8'h00;
        tick(1);
        spi.sen_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            spi.sclk = 1'b0;
            spi.sdi = frame[i];
            tick(HALF);
            if (i < 8) rdata[i] = sdout;
            spi.sclk = 1'b1;
            tick(HALF);
        end
        tick(4);
        spi.sen_n = 1'b1;
        tick(1);
        spi.sclk = 1'b0;
        // Deselected line shows the inverse, never a stale bit
        spi.sdi = ~frame[0];
        tick(8);
    endtask
endmodule
`default_nettype wire

// >>> dv/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
    import aoipr_pkg::*;
    logic        sys_clk;
    logic        nrst;
    aoipr_spi_t  spi_in;
    logic        sdout;
    logic        sdout_oe;
    logic [2:0]  fuse_map;
    logic [2:0]  fuse_lane;
    aoipr_map_t  map_o;
    aoipr_lane_t lane_o;
    aoipr_pwr_t  pwr_o;
    int          bad_count;
    int          samples_checked;
    int          regs[32];
    int          map_eff;
    bit          wr07;
    int          addrs[$] = '{7, 8, 9, 13, 19, 10, 1023};
    aoipr_map_t  map_tab[8] = '{MAP_UNUSED, MAP_TWO_LANE_18_14, MAP_TWO_LANE_16, MAP_ONE_LANE,
                                MAP_HALF_LANE, MAP_UNUSED, MAP_UNUSED, MAP_UNUSED};
    aoipr_lane_t lane_tab[8] = '{LANE_UNUSED, LANE_UNUSED, LANE_UNUSED, LANE_TWO,
                                 LANE_ONE, LANE_HALF, LANE_UNUSED, LANE_UNUSED};
    aoipr_regs i_dut (.sys_clk(sys_clk), .nrst(nrst), .spi_in(spi_in), .sdout(sdout),
        .sdout_oe(sdout_oe), .fuse_bit_mapping(fuse_map), .fuse_lane_mode(fuse_lane),
        .output_bit_mapping(map_o), .lane_mode(lane_o), .pwr(pwr_o));
    aoipr_spi_host i_host (.sys_clk(sys_clk), .spi(spi_in), .sdout(sdout));
    function automatic aoipr_pwr_t exp_pwr();
        logic [7:0] c;
        logic [7:0] o;
        logic [7:0] m;
        c = 8'(regs[8]);
        o = 8'(regs[9]);
        m = 8'(regs[13]);
        return '{c[5] | (c[0] & ~m[3]), c[4] | (c[0] & ~m[2]), c[0] & m[1], c[2] | c[0],
                 c[1] | c[0], o[5], o[4], o[3], o[2], o[1], o[0]};
    endfunction
    task automatic cmp(input string what, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask
    task automatic chk_outs();
        logic [2:0] sel;
        sel = regs[7][3] ? 3'(regs[7]) : fuse_lane;
        cmp("bit mapping", 16'(map_tab[map_eff]), 16'(map_o));
        cmp("lane mode", 16'(lane_tab[sel]), 16'(lane_o));
        cmp("power controls", 16'(exp_pwr()), 16'(pwr_o));
    endtask
    task automatic wr(input int a, input logic [7:0] d);
        logic [7:0] q;
        i_host.xfer(1'b0, 12'(a), d, q);
        if (a == 19) begin
            map_eff = wr07 ? regs[7] >> 5 : fuse_map;
            regs[8] = 0;
            regs[9] = 0;
            regs[13] = 0;
        end else begin
            regs[a] = d;
            wr07 |= (a == 7);
        end
    endtask
    task automatic chk_reg(input int a);
        logic [7:0] q;
        i_host.xfer(1'b1, 12'(a), 8'h00, q);
        cmp("read data", 16'(a < 32 ? regs[a] : 0), {8'h00, q});
    endtask
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ****************************************
    // Clock, watchdog and main sequence
    // ****************************************
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (100000) @(posedge sys_clk);
        bad_count++;
        $display("unexpected run length: expected done, seen still running");
        print_verdict();
    end
    initial begin
        nrst = 1'b0;
        void'($urandom(32'h98854701));
        fuse_map = 3'($urandom_range(4, 1));
        fuse_lane = 3'($urandom_range(5, 3));
        map_eff = fuse_map;
        repeat (6) @(posedge sys_clk);
        #1 nrst = 1'b1;
        repeat (6) @(posedge sys_clk);
        foreach (addrs[k]) chk_reg(addrs[k]);
        chk_outs();
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            wr(7, {3'(i), 1'b0, 1'b1, 3'(i)});
            chk_outs();
            wr(19, 8'h01);
            chk_outs();
            chk_reg(7);
        end
        wr(7, 8'h45);
        chk_outs();
        $display("test interface done");
        for (int i = 0; i < 12; i++) begin
            if (i % 4 == 0) wr(13, 8'($urandom) & 8'h0e);
            wr(8, 8'($urandom) & 8'h37);
            wr(9, 8'($urandom) & 8'h3f);
            chk_outs();
            chk_reg(8);
            chk_reg(9);
            chk_reg(13);
        end
        wr(19, 8'h01);
        chk_outs();
        chk_reg(8);
        $display("test power done");
        print_verdict();
    end
endmodule
`default_nettype wire
